/* common/card_unit_pkg.sv */
package card_unit_pkg;

  // Instruction bytes
  localparam logic [7:0] OP_START   = 8'hf3;
  localparam logic [7:0] OP_ADVANCE = 8'hf1;
  localparam logic [7:0] OP_TEST_A  = 8'hc1;
  localparam logic [7:0] OP_TEST_B  = 8'hd1;
  localparam logic [7:0] OP_TEST_C  = 8'he1;
  localparam logic [7:0] OP_LOAD_A  = 8'h31;
  localparam logic [7:0] OP_LOAD_B  = 8'h71;
  localparam logic [7:0] OP_LOAD_C  = 8'hb1;
  localparam logic [3:0] DEV_SEL    = 4'hf;
  localparam logic [7:0] ADV_R_BYTE = 8'h00;

  // Start function codes (N field of the start command)
  localparam logic [2:0] FN_FEED       = 3'h0;
  localparam logic [2:0] FN_READ       = 3'h1;
  localparam logic [2:0] FN_PUNCH_FEED = 3'h2;
  localparam logic [2:0] FN_PUNCH_READ = 3'h3;
  localparam logic [2:0] FN_PRINT      = 3'h4;
  localparam logic [2:0] FN_INT_CTRL   = 3'h7;

  // Control code: stacker field and interrupt control bits
  localparam logic [2:0] STK_ALT      = 3'h5;
  localparam logic [2:0] STK_DEFAULT  = 3'h0;
  localparam logic [2:0] STK_FOUR     = 3'h4;
  localparam int         CC_INT_EN    = 7;
  localparam int         CC_INT_DIS   = 6;
  localparam int         CC_INT_RST   = 5;

  // Load targets
  localparam logic [2:0] LD_READ_LEN   = 3'h0;
  localparam logic [2:0] LD_PUNCH_LEN  = 3'h2;
  localparam logic [2:0] LD_PRINT      = 3'h3;
  localparam logic [2:0] LD_PRINT_ADDR = 3'h4;
  localparam logic [2:0] LD_READ_ADDR  = 3'h5;
  localparam logic [2:0] LD_PUNCH_ADDR = 3'h6;
  localparam logic [7:0] MAX_PRINT_LEN = 8'h40;
  localparam logic [7:0] MAX_RP_LEN    = 8'h50;
  localparam int         HEAD_W        = 6;

  // Test conditions
  localparam logic [2:0] TC_BUSY      = 3'h0;
  localparam logic [2:0] TC_INT_PEND  = 3'h1;
  localparam logic [2:0] TC_INT_EN    = 3'h2;
  localparam logic [2:0] TC_NOT_READY = 3'h3;
  localparam logic [2:0] TC_CHECK     = 3'h4;
  localparam logic [2:0] TC_PRINT_CARD = 3'h5;

  localparam logic [2:0] IRQ_LEVEL = 3'h5;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  qByte;
    logic [7:0]  rByte;
    logic [15:0] operand;
    logic [15:0] nextSeq;
    logic [7:0]  loadHi;
    logic [7:0]  loadLo;
  } cmd_t;

  typedef enum logic [1:0] {ACT_SEQ, ACT_BRANCH, ACT_LOOP, ACT_SWITCH} action_t;

  typedef struct packed {
    logic        accepted;
    action_t     action;
    logic [15:0] iar;
    logic [15:0] recall;
  } resp_t;

  typedef struct packed {
    logic [2:0] func;
    logic       feed;
    logic [2:0] stacker;
    logic       stackValid;
  } mech_t;

  typedef struct packed {
    logic [7:0]        readLen;
    logic [7:0]        punchLen;
    logic [7:0]        printLen;
    logic [HEAD_W-1:0] heads;
    logic [15:0]       readAddr;
    logic [15:0]       punchAddr;
    logic [15:0]       printAddr;
  } load_t;

  typedef struct packed {
    logic       mechDone;
    logic       dataCheck;
    logic       machineCheck;
    logic       feedCheck;
    logic       notReady;
    logic       intervention;
    logic       mechBusy;
    logic [1:0] hopper;
    logic [1:0] prepunch;
  } pins_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_END = 2'b11} state_t;

endpackage

/* hw/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 11
) (
  input  wire logic         mclk,
  input  wire logic         rstN,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // Two stages per pin; only the second stage is ever read
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
          meta[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else if (clkEn) begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* hw/load_reg_file.sv */
`timescale 1ns/1ps
`default_nettype none
module load_reg_file
  import card_unit_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstN,
  input  wire logic       clkEn,
  input  wire logic       loadEn,
  input  wire logic [2:0] nCode,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] lo,
  output load_t           regs
);

  // Oversized counts saturate instead of wrapping
  function automatic logic [7:0] clampLen(input logic [7:0] v, input logic [7:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // Load targets; diagnostic and invalid codes are ignored
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      regs <= '0;
    end else if (clkEn && loadEn) begin
      case (nCode)
        LD_READ_LEN:   regs.readLen <= clampLen(hi, MAX_RP_LEN);
        LD_PUNCH_LEN:  regs.punchLen <= clampLen(lo, MAX_RP_LEN);
        LD_PRINT: begin
          regs.heads    <= hi[HEAD_W-1:0];
          regs.printLen <= clampLen(lo, MAX_PRINT_LEN);
        end
        LD_PRINT_ADDR: regs.printAddr <= {hi, lo};
        LD_READ_ADDR:  regs.readAddr <= {hi, lo};
        LD_PUNCH_ADDR: regs.punchAddr <= {hi, lo};
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

/* hw/card_unit_io_attachment.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Start is opcode F3, no operand; Q-byte high nibble all ones selects us
// - Accepted start runs the coded function on the chosen feed
// - Stacker field 000/110/111 default; 101 on faster model goes to stacker 4
// - Stacker choice applies only to a prepunch card; ignored if station empty
// - Missing card aborts with no-op and op-end; read without card forces feed
// - Unresolved check or unsensed no-op/data check aborts with no-op and op-end
// - Zero loaded length count for the operation aborts with no-op and op-end
// - Print with zero heads loaded aborts with no-op and op-end
// - Start while not ready turns on the attention indicator
// - Interrupt control start is always accepted
// - Op-end request on level 5 after every accepted start other than interrupt control: normal, error or no-op
// - Interrupt enable/disable/reset any time; testable; cause readable by sense
// - Test-and-branch C1/D1/E1 branches to operand when condition holds
// - On branch recall gets next sequential address, IAR gets the target
// - Advance level F1, R-byte zero: switch, loop or continue per condition
// - Primary punch-read registers punched card at print; printed card stacks
// - Load C1-class opcodes 31/71/B1 move two bytes into an address or print register, one into a read or punch count
// - Loaded counts clamp to 40 hex for print, 50 hex for read and punch
module card_unit_io_attachment
  import card_unit_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  input  wire logic       cmdValid,
  input  wire cmd_t       cmd,
  input  wire pins_t      pins,
  input  wire logic       fasterModel,
  input  wire logic       dualEnabled,
  input  wire logic       senseRead,
  output logic            cmdDone,
  output resp_t           resp,
  output logic            mechStart,
  output mech_t           mech,
  output logic            irqRequest,
  output logic      [2:0] irqLevel,
  output logic            intEnabled,
  output logic            intPending,
  output logic            attention,
  output logic      [1:0] feedBusy,
  output logic      [7:0] senseByte,
  output logic            printStationFull,
  output logic            stackPrinted
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic   rstMeta;
  logic   rstN;
  pins_t  pinSync;
  load_t  loadRegs;
  state_t state;
  logic   donePrev;
  logic   dataChkPrev;
  logic   unsensedNoOp;
  logic   unsensedDataChk;
  logic   ranOp;
  logic   printedCard;

  // Release is clocked so every flop leaves reset on the same edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else if (clkEn) begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  pin_sync #(.W($bits(pins_t))) u_sync (
    .mclk  (mclk),
    .rstN  (rstN),
    .clkEn (clkEn),
    .din   (pins),
    .dout  (pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic devSel(input logic [7:0] q);
    return q[7:4] == DEV_SEL;
  endfunction

  function automatic logic oneOf(input logic [7:0] op, input logic [7:0] a,
                                 input logic [7:0] b, input logic [7:0] c);
    return (op == a) || (op == b) || (op == c);
  endfunction

  // Faster model alone honours the alternate stacker code
  function automatic logic [2:0] stackerCode(input logic [2:0] cc, input logic fast);
    return (cc == STK_ALT && fast) ? STK_FOUR : STK_DEFAULT;
  endfunction

  logic       take;
  logic       isStart;
  logic       isTest;
  logic       isAdv;
  logic       isLoad;
  logic [2:0] nCode;
  logic       feedSel;
  logic       intCtrl;
  logic       blocked;
  logic       checkAbort;
  logic       lenZero;
  logic       noCard;
  logic       accept;
  logic       abort;
  logic       runOp;
  logic [2:0] runFunc;
  logic       cond;
  logic       doneRise;
  logic       dataChkRise;

  assign take    = cmdValid && clkEn;
  assign nCode   = cmd.qByte[2:0];
  assign feedSel = cmd.qByte[3];
  assign isStart = take && cmd.opcode == OP_START && devSel(cmd.qByte);
  assign isTest  = take && oneOf(cmd.opcode, OP_TEST_A, OP_TEST_B, OP_TEST_C)
                   && devSel(cmd.qByte);
  assign isAdv   = take && cmd.opcode == OP_ADVANCE && devSel(cmd.qByte)
                   && cmd.rByte == ADV_R_BYTE;
  assign isLoad  = take && oneOf(cmd.opcode, OP_LOAD_A, OP_LOAD_B, OP_LOAD_C)
                   && devSel(cmd.qByte);
  assign intCtrl = nCode == FN_INT_CTRL;

  // Busy, intervention or not ready: refused so the host loops
  assign blocked = state != ST_IDLE || pinSync.mechBusy || pinSync.intervention
                   || pinSync.notReady;
  assign checkAbort = pinSync.machineCheck || pinSync.feedCheck
                      || unsensedNoOp || unsensedDataChk;

  // Abort conditions that need the function code
  always_comb begin
    lenZero = 1'b0;
    noCard  = 1'b0;
    runFunc = nCode;
    case (nCode)
      FN_FEED: noCard = !pinSync.hopper[feedSel] && !pinSync.prepunch[feedSel];
      FN_READ: begin
        lenZero = loadRegs.readLen == '0;
        if (!pinSync.hopper[feedSel]) begin
          runFunc = FN_FEED;
        end
      end
      FN_PUNCH_FEED: begin
        lenZero = loadRegs.punchLen == '0;
        noCard  = !pinSync.prepunch[feedSel];
      end
      FN_PUNCH_READ: begin
        lenZero = loadRegs.punchLen == '0 || loadRegs.readLen == '0;
        noCard  = !pinSync.prepunch[feedSel];
      end
      FN_PRINT: begin
        lenZero = loadRegs.printLen == '0 || loadRegs.heads == '0;
        noCard  = !printStationFull;
      end
      default: ;
    endcase
  end

  assign accept = isStart && (intCtrl || !blocked);
  assign abort  = accept && !intCtrl && (checkAbort || lenZero || noCard);
  assign runOp  = accept && !intCtrl && !abort;

  // Conditions shared by test-and-branch and advance level
  always_comb begin
    case (nCode)
      TC_BUSY:       cond = feedBusy[feedSel];
      TC_INT_PEND:   cond = intPending;
      TC_INT_EN:     cond = intEnabled;
      TC_NOT_READY:  cond = pinSync.notReady;
      TC_CHECK:      cond = pinSync.machineCheck || pinSync.feedCheck;
      TC_PRINT_CARD: cond = printStationFull;
      default:       cond = 1'b0;
    endcase
  end

  assign doneRise    = pinSync.mechDone && !donePrev;
  assign dataChkRise = pinSync.dataCheck && !dataChkPrev;

  load_reg_file u_load (
    .mclk   (mclk),
    .rstN   (rstN),
    .clkEn  (clkEn),
    .loadEn (isLoad),
    .nCode  (nCode),
    .hi     (cmd.loadHi),
    .lo     (cmd.loadLo),
    .regs   (loadRegs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Edge history of synchronised pins
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      donePrev    <= 1'b0;
      dataChkPrev <= 1'b0;
    end else if (clkEn) begin
      donePrev    <= pinSync.mechDone;
      dataChkPrev <= pinSync.dataCheck;
    end
  end

  // Aborts skip the run phase but still pass through op-end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state <= ST_IDLE;
    end else if (clkEn) begin
      case (state)
        ST_IDLE: begin
          if (runOp) begin
            state <= ST_RUN;
          end else if (abort) begin
            state <= ST_END;
          end
        end
        ST_RUN: begin
          if (doneRise) begin
            state <= ST_END;
          end
        end
        ST_END:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Answer to the host, one cycle after the command is taken
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cmdDone <= 1'b0;
      resp    <= '0;
    end else if (clkEn) begin
      cmdDone       <= take;
      resp.accepted <= accept || isTest || isAdv || isLoad;
      resp.iar      <= cmd.nextSeq;
      resp.recall   <= cmd.nextSeq;
      resp.action   <= ACT_SEQ;
      if (isTest && cond) begin
        resp.action <= ACT_BRANCH;
        resp.iar    <= cmd.operand;
      end else if (isAdv && cond) begin
        resp.action <= dualEnabled ? ACT_SWITCH : ACT_LOOP;
      end else if (isStart && !accept) begin
        resp.action <= ACT_LOOP;
      end
    end
  end

  // Transport command; stacker choice only for a card at prepunch
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      mechStart <= 1'b0;
      mech      <= '0;
      ranOp     <= 1'b0;
    end else if (clkEn) begin
      mechStart <= runOp;
      if (runOp) begin
        mech.func       <= runFunc;
        mech.feed       <= feedSel;
        mech.stackValid <= pinSync.prepunch[feedSel];
        mech.stacker    <= pinSync.prepunch[feedSel]
                           ? stackerCode(cmd.rByte[2:0], fasterModel) : STK_DEFAULT;
        ranOp           <= 1'b1;
      end else if (state == ST_END) begin
        ranOp <= 1'b0;
      end
    end
  end

  // Feed busy spans the whole run
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      feedBusy <= '0;
    end else if (clkEn) begin
      if (runOp) begin
        feedBusy[feedSel] <= 1'b1;
      end else if (state == ST_END) begin
        feedBusy <= '0;
      end
    end
  end

  // Interrupt enable and pending; an op-end beats a simultaneous reset
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      intEnabled <= 1'b0;
      intPending <= 1'b0;
    end else if (clkEn) begin
      if (isStart && intCtrl && cmd.rByte[CC_INT_EN]) begin
        intEnabled <= 1'b1;
      end else if (isStart && intCtrl && cmd.rByte[CC_INT_DIS]) begin
        intEnabled <= 1'b0;
      end
      if (state == ST_END) begin
        intPending <= 1'b1;
      end else if (isStart && intCtrl && cmd.rByte[CC_INT_RST]) begin
        intPending <= 1'b0;
      end
    end
  end

  assign irqRequest = intEnabled && intPending;
  assign irqLevel   = IRQ_LEVEL;

  // Unsensed status: new events win over the clearing sense
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      unsensedNoOp    <= 1'b0;
      unsensedDataChk <= 1'b0;
      senseByte       <= '0;
    end else if (clkEn) begin
      if (abort) begin
        unsensedNoOp <= 1'b1;
      end else if (senseRead) begin
        unsensedNoOp <= 1'b0;
      end
      if (dataChkRise) begin
        unsensedDataChk <= 1'b1;
      end else if (senseRead) begin
        unsensedDataChk <= 1'b0;
      end
      if (senseRead) begin
        senseByte <= {unsensedNoOp, unsensedDataChk, pinSync.machineCheck,
                      pinSync.feedCheck, pinSync.notReady, pinSync.intervention,
                      intPending, 1'b0};
      end
    end
  end

  // Attention follows any start while not ready, interrupt control included
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      attention <= 1'b0;
    end else if (clkEn) begin
      if (isStart && pinSync.notReady) begin
        attention <= 1'b1;
      end else if (!pinSync.notReady) begin
        attention <= 1'b0;
      end
    end
  end

  // Print station tracking; the transport reports no print-station sensor
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      printStationFull <= 1'b0;
      printedCard      <= 1'b0;
      stackPrinted     <= 1'b0;
    end else if (clkEn) begin
      stackPrinted <= 1'b0;
      if (state == ST_END && ranOp) begin
        if (mech.func == FN_PUNCH_READ && !mech.feed) begin
          printStationFull <= 1'b1;
          printedCard      <= 1'b0;
          stackPrinted     <= printedCard;
        end else if (mech.func == FN_PRINT) begin
          printStationFull <= 1'b0;
          printedCard      <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN || !clkEn);

  wrongDevice_a: assert property ((take && cmd.opcode == OP_START
    && !devSel(cmd.qByte)) |=> !mechStart)
    else $error("start for another device ran the transport");
  funcFeed_a: assert property (runOp |=> mechStart
    && mech.feed == $past(cmd.qByte[3]))
    else $error("transport not started on the selected feed");
  stackerFour_a: assert property ((runOp && cmd.rByte[2:0] == STK_ALT && fasterModel
    && pinSync.prepunch[feedSel]) |=> mech.stacker == STK_FOUR)
    else $error("alternate stacker code not routed to stacker four");
  stackIgnore_a: assert property ((mechStart && !mech.stackValid)
    |-> mech.stacker == STK_DEFAULT)
    else $error("stacker choice used with empty prepunch");
  abortEnd_a: assert property (abort |=> state == ST_END ##1 intPending
    && unsensedNoOp)
    else $error("abort did not give no-op and op-end");
  checkAbort_a: assert property ((isStart && !intCtrl && !blocked && checkAbort)
    |=> !mechStart)
    else $error("start ran despite pending check");
  zeroLen_a: assert property ((isStart && nCode == FN_READ && loadRegs.readLen == '0)
    |=> !mechStart)
    else $error("start ran with zero length count");
  noHeads_a: assert property ((isStart && !blocked && nCode == FN_PRINT
    && loadRegs.heads == '0) |=> !mechStart && unsensedNoOp)
    else $error("print ran with no heads selected");
  attnOn_a: assert property ((isStart && pinSync.notReady) |=> attention)
    else $error("not ready start left attention off");
  intCtrlTaken_a: assert property ((isStart && intCtrl) |=> resp.accepted)
    else $error("interrupt control start refused");
  opEndRaise_a: assert property ((state == ST_RUN && doneRise) |=> ##1 intPending
    && irqLevel == IRQ_LEVEL)
    else $error("op-end not requested after run");
  branchAddr_a: assert property ((isTest && cond) |=> resp.action == ACT_BRANCH
    && resp.iar == $past(cmd.operand) && resp.recall == $past(cmd.nextSeq))
    else $error("branch addresses wrong");
  advLevel_a: assert property ((isAdv && cond) |=> resp.action
    == ($past(dualEnabled) ? ACT_SWITCH : ACT_LOOP))
    else $error("advance level outcome wrong");
  busyClear_a: assert property (state == ST_END |=> feedBusy == '0)
    else $error("feed busy stuck after op-end");

  abortSeen_c: cover property (abort ##2 intPending);
  runSeen_c: cover property (runOp ##[1:50] state == ST_END);
  branchSeen_c: cover property (isTest && cond);
  switchSeen_c: cover property (isAdv && cond && dualEnabled);

endmodule
`default_nettype wire

/* verif/card_transport_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Transport stand-in: finishes each started function after lag cycles
module card_transport_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       mechStart,
  input  wire logic [7:0] lag,
  output logic            mechDone,
  output logic            mechBusy
);
  logic [7:0] count;

  // Done stays high until the next start so the pin sync cannot miss it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count    <= 8'h00;
      mechDone <= 1'b0;
    end else if (mechStart) begin
      count    <= lag;
      mechDone <= 1'b0;
    end else if (count > 8'h01) begin
      count <= count - 8'h01;
    end else if (count == 8'h01) begin
      count    <= 8'h00;
      mechDone <= 1'b1;
    end
  end

  assign mechBusy = (count != 8'h00);
endmodule
`default_nettype wire

/* verif/card_unit_io_attachment_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module card_unit_io_attachment_bench
  import card_unit_pkg::*;
;
  logic        mclk, resetn, clkEn, cmdValid, fasterModel, dualEnabled, senseRead;
  logic        cmdDone, mechStart, irqRequest, intEnabled, intPending, attention;
  logic        printStationFull, mechDone, mechBusy, stackPrinted;
  logic [1:0]  feedBusy;
  logic [2:0]  irqLevel, code;
  logic [7:0]  senseByte, lag;
  logic [15:0] opd, nxt;
  logic [7:0]  tops [3] = '{OP_TEST_A, OP_TEST_B, OP_TEST_C};
  logic [2:0]  stks [4] = '{3'h0, 3'h6, 3'h7, STK_ALT};
  cmd_t        cmd;
  resp_t       resp;
  mech_t       mech;
  pins_t       pinsTb, pins;
  int          seed, failCount, nChecks, i, k;
  int          stackCount = 0;

  card_unit_io_attachment u_card_unit_io_attachment (.mclk, .resetn, .clkEn, .cmdValid,
    .cmd, .pins, .fasterModel, .dualEnabled, .senseRead, .cmdDone, .resp, .mechStart,
    .mech, .irqRequest, .irqLevel, .intEnabled, .intPending, .attention, .feedBusy,
    .senseByte, .printStationFull, .stackPrinted);
  card_transport_model u_card_transport_model (.mclk, .resetn, .mechStart, .lag,
    .mechDone, .mechBusy);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and pins merged from bench levels and the transport
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always_comb begin
    pins          = pinsTb;
    pins.mechDone = mechDone;
    pins.mechBusy = mechBusy;
  end
  // Stacked printed cards; the pulse stands one cycle, so one look per negedge
  always @(negedge mclk) begin
    if (stackPrinted === 1'b1) stackCount++;
  end

  function automatic logic [2:0] expStk(input logic [2:0] c, input logic fast);
    return (c == STK_ALT && fast) ? STK_FOUR : STK_DEFAULT;
  endfunction

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One command strobe; the answer is looked at in the cycle it stands
  task automatic issue(input logic [7:0] op, q, r, input logic [15:0] o, n,
                       input logic [7:0] hi, lo);
    @(negedge mclk);
    cmd      = {op, q, r, o, n, hi, lo};
    cmdValid = 1'b1;
    @(negedge mclk);
    cmdValid = 1'b0;
    chk("cmdDone", 1, cmdDone);
  endtask

  task automatic start(input logic [2:0] fn, input logic [7:0] r);
    issue(OP_START, {DEV_SEL, 1'b0, fn}, r, 16'h0, 16'h0, 8'h0, 8'h0);
  endtask

  task automatic load(input logic [2:0] n, input logic [7:0] hi, lo);
    issue(OP_LOAD_A, {DEV_SEL, 1'b0, n}, 8'h0, 16'h0100, 16'h0, hi, lo);
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  // Wait for op end, read the cause, then reset the pending interrupt
  task automatic finishOp(input logic noOp);
    for (i = 0; i < 100 && intPending !== 1'b1; i++) @(negedge mclk);
    chk("intPending", 1, intPending);
    chk("irqRequest", 1, irqRequest);
    chk("feedBusy", 0, feedBusy);
    senseRead = 1'b1;
    @(negedge mclk);
    senseRead = 1'b0;
    @(negedge mclk);
    chk("noOpBit", noOp, senseByte[7]);
    start(FN_INT_CTRL, 8'h20);
    chk("pendReset", 0, intPending);
  endtask

  initial begin
    #300000;
    failCount++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {clkEn, seed, lag} = {1'b1, 32'd21268, 8'h04};
    {cmdValid, cmd, pinsTb, fasterModel, dualEnabled, senseRead, resetn} = '0;
    {failCount, nChecks} = '0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    pinsTb.notReady = 1'b1;
    settle();
    chk("irqLevel", IRQ_LEVEL, irqLevel);
    start(FN_INT_CTRL, 8'h80);
    chk("ctlTaken", 1, resp.accepted);
    chk("intEnabled", 1, intEnabled);
    start(FN_FEED, 8'h0);
    chk("refused", 0, resp.accepted);
    chk("loop", ACT_LOOP, resp.action);
    chk("attention", 1, attention);
    pinsTb = '0;
    pinsTb.hopper = 2'b11;
    pinsTb.prepunch = 2'b01;
    settle();
    foreach (tops[j]) begin
      opd = $random(seed);
      nxt = $random(seed);
      issue(tops[j], {DEV_SEL, 1'b0, TC_INT_EN}, 8'h0, opd, nxt, 8'h0, 8'h0);
      chk("branch", {ACT_BRANCH, opd, nxt}, {resp.action, resp.iar, resp.recall});
      issue(tops[j], {DEV_SEL, 1'b0, TC_INT_PEND}, 8'h0, opd, nxt, 8'h0, 8'h0);
      chk("seq", {ACT_SEQ, nxt}, {resp.action, resp.iar});
    end
    for (k = 0; k < 2; k++) begin
      dualEnabled = k[0];
      issue(OP_ADVANCE, {DEV_SEL, 1'b0, TC_INT_EN}, ADV_R_BYTE, 16'h0, 16'h0, 8'h0, 8'h0);
      chk("advance", k ? ACT_SWITCH : ACT_LOOP, resp.action);
    end
    issue(OP_ADVANCE, {DEV_SEL, 1'b0, TC_INT_PEND}, ADV_R_BYTE, 16'h0, 16'h0, 8'h0, 8'h0);
    chk("advSeq", ACT_SEQ, resp.action);
    load(LD_READ_LEN, 8'h00, 8'h00);
    start(FN_READ, 8'h0);
    finishOp(1'b1);
    load(LD_READ_LEN, 8'hff, 8'h00);
    for (k = 0; k < 8; k++) begin
      code = stks[$unsigned($random(seed)) % 4];
      fasterModel = $random(seed);
      pinsTb.hopper[0] = $random(seed);
      pinsTb.prepunch[0] = !pinsTb.hopper[0] || $random(seed);
      lag = 8'h02 + ($unsigned($random(seed)) % 30);
      settle();
      start(FN_READ, {5'h0, code});
      chk("mechStart", 1, mechStart);
      chk("func", pinsTb.hopper[0] ? FN_READ : FN_FEED, mech.func);
      chk("stkValid", pinsTb.prepunch[0], mech.stackValid);
      if (pinsTb.prepunch[0]) chk("stacker", expStk(code, fasterModel), mech.stacker);
      chk("busy", 1, feedBusy[0]);
      finishOp(1'b0);
    end
    {pinsTb.hopper, pinsTb.prepunch} = 4'hf;
    settle();
    load(LD_PUNCH_LEN, 8'h00, 8'h10);
    start(FN_PUNCH_READ, 8'h0);
    finishOp(1'b0);
    chk("printFull", 1, printStationFull);
    pinsTb.machineCheck = 1'b1;
    settle();
    start(FN_FEED, 8'h0);
    finishOp(1'b1);
    pinsTb.machineCheck = 1'b0;
    settle();
    load(LD_PRINT, 8'h00, 8'h10);
    start(FN_PRINT, 8'h0);
    finishOp(1'b1);
    load(LD_PRINT, 8'h01, 8'h10);
    start(FN_PRINT, 8'h0);
    finishOp(1'b0);
    chk("printEmpty", 0, printStationFull);
    start(FN_PUNCH_READ, 8'h0);
    finishOp(1'b0);
    chk("stacked", 1, stackCount);
    end_sim();
  end
endmodule
`default_nettype wire
